//--- core/tsr_pkg.sv
// constants and types for the thermal sensor smbus register block
package tsr_pkg;
   localparam logic [7:0] CMD_RESERVED        = 8'h00;
   localparam logic [7:0] READ_TEMP_CMD       = 8'h01;
   localparam logic [7:0] READ_STATUS_CMD     = 8'h02;
   localparam logic [7:0] READ_CONFIG_CMD     = 8'h03;
   localparam logic [7:0] READ_RATE_CMD       = 8'h04;
   localparam logic [7:0] READ_HIGH_LIMIT_CMD = 8'h07;
   localparam logic [7:0] READ_LOW_LIMIT_CMD  = 8'h08;
   localparam logic [7:0] WRITE_CONFIG_CMD    = 8'h09;
   localparam logic [7:0] WRITE_RATE_CMD      = 8'h0A;
   localparam logic [7:0] WRITE_HIGH_LIMIT_CMD= 8'h0D;
   localparam logic [7:0] WRITE_LOW_LIMIT_CMD = 8'h0E;
   localparam logic [7:0] SINGLE_CONVERSION_CMD = 8'h0F;
   localparam logic [7:0] CONFIG_RESET        = 8'h00;
   localparam logic [7:0] RATE_RESET          = 8'h02;
   localparam logic [7:0] HIGH_LIMIT_RESET    = 8'h7F;
   localparam logic [7:0] LOW_LIMIT_RESET     = 8'hC9;
   localparam logic [6:0] ARA_ADDR            = 7'h0C;
   localparam logic [3:0] ADDR_HI_SA2_LOW     = 4'h3;
   localparam logic [3:0] ADDR_HI_SA2_FLOAT   = 4'h5;
   localparam logic [3:0] ADDR_HI_SA2_HIGH    = 4'h9;
   localparam int         CFG_STANDBY_BIT     = 6;
   localparam int         ST_BUSY_BIT         = 7;
   localparam int         ST_HIGH_BIT         = 4;
   localparam int         ST_LOW_BIT          = 3;
   localparam int         ST_OPEN_BIT         = 2;
   localparam logic [7:0] RATE_MAX_CODE       = 8'h07;
   localparam int         CLK_HZ              = 100_000_000;
   // slowest interval 16 s, code n gives 16 s >> n
   localparam int         SLOWEST_PERIOD_S    = 16;
   localparam logic [35:0] SLOWEST_CYCLES     = 36'(longint'(SLOWEST_PERIOD_S) * CLK_HZ);
   localparam int         CONV_TIME_US        = 100;
   localparam int         CONV_CYCLES         = CONV_TIME_US * (CLK_HZ / 1_000_000);

   typedef enum logic [3:0] {
      BS_IDLE  = 4'b0000,
      BS_ADDR  = 4'b0001,
      BS_AACK  = 4'b0011,
      BS_RXB   = 4'b0010,
      BS_RACK  = 4'b0110,
      BS_TXB   = 4'b0111,
      BS_TACK  = 4'b0101,
      BS_WAITP = 4'b0100
   } tsr_bus_t;

   typedef struct packed {
      logic [1:0]  scl_sy;
      logic [1:0]  sda_sy;
      logic        scl_q;
      logic        sda_q;
      tsr_bus_t    bst;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [1:0]  bytenum;
      logic        is_ara;
      logic        is_read;
      logic [7:0]  cmd;
      logic        rd_valid;
      logic        sda_oe;
      logic [7:0]  temp;
      logic [7:0]  config_r;
      logic [7:0]  rate;
      logic [7:0]  high_lim;
      logic [7:0]  low_lim;
      logic        high_flag;
      logic        low_flag;
      logic        open_flag;
      logic        busy;
      logic        single;
      logic [31:0] conv_cnt;
      logic [35:0] rate_cnt;
      logic        alert;
      logic        status_rd;
   } tsr_state_t;
endpackage

//--- core/tsr_top.sv
// smbus slave with thermal sensor registers, conversion timer and alarms
// What this block does
// - answer only write byte, read byte, send byte, receive byte and alert response.
// - receive byte returns register chosen by latest command byte of any write byte, read byte or send byte.
// - write byte: address, command, data, each acknowledged, then stop.
// - read byte: address, command, restart, address read, data, host nack.
// - send byte has command only; receive byte returns data then host nack.
// - alert response read returns own 7-bit address in upper bits.
// - codes 01h, 02h, 03h read temperature, status, configuration.
// - codes 04h, 07h, 08h read rate, high limit, low limit.
// - reset values: config 00h, rate 02h, high 7Fh, low C9h.
// - write 09h loads configuration, 0Ah loads conversion rate.
// - write 0Dh loads high limit, 0Eh loads low limit.
// - single conversion command starts conversion now, ignored while busy.
// - in standby a single conversion runs once then returns to standby.
// - in auto mode single conversion restarts the rate timer.
// - command pointer resets to 00h; receive byte invalid until new command.
// - temperature is two's complement, saturated to 127 and -128.
// - reading at or beyond a limit sets the matching alarm flag.
// - alarm flags sticky, cleared by status read unless condition persists.
// - status bit7 busy, bit4 high, bit3 low, bit2 open, others zero.
// - config bit6 set halts converting and enters standby; clear is auto.
// - rate codes 00h to 07h double from 0.0625 Hz to 8 Hz.
// - alert output asserts when either limit is crossed.
// - claim address 0011, 0101 or 1001 upper bits with slot pin bits.
`timescale 1ns/1ps
module tsr_top #(
   parameter logic [35:0] SLOWEST_CYCLES = tsr_pkg::SLOWEST_CYCLES,
   parameter int          CONV_CYCLES    = tsr_pkg::CONV_CYCLES
) (
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic              SCL,
   input  wire logic              SDA_IN,
   output logic                   SDA_OUT,
   output logic                   SDA_OE,
   output logic                   ALERT_N_OUT,
   output logic                   ALERT_N_OE,
   input  wire logic              SA1,
   input  wire logic [1:0]        SA2_MODE,
   input  wire logic signed [9:0] ADC_RESULT,
   input  wire logic              ADC_OPEN,
   output logic                   CONV_ACTIVE
);
   tsr_pkg::tsr_state_t s_reg;
   tsr_pkg::tsr_state_t s_next;

   logic [6:0]  my_addr;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic [7:0]  rd_data;
   logic [7:0]  sat;
   logic [7:0]  status_v;
   logic        hi_cond;
   logic        lo_cond;
   logic [35:0] interval;
   logic        conv_done;
   logic        start_conv;
   logic        auto_mode;

   ////////////////////////////////////////////////////////////////////////////
   // address and read mux
   always_comb begin
      // SA2_MODE: 0 low, 1 floating, 2 high
      case (SA2_MODE)
         2'd0:    my_addr = {tsr_pkg::ADDR_HI_SA2_LOW, 1'b0, SA1, 1'b0};
         2'd1:    my_addr = {tsr_pkg::ADDR_HI_SA2_FLOAT, 1'b0, SA1, 1'b1};
         default: my_addr = {tsr_pkg::ADDR_HI_SA2_HIGH, 1'b1, SA1, 1'b0};
      endcase
   end

   assign hi_cond  = $signed(s_reg.temp) >= $signed(s_reg.high_lim);
   assign lo_cond  = $signed(s_reg.temp) <= $signed(s_reg.low_lim);
   assign status_v = {s_reg.busy, 2'b00, s_reg.high_flag, s_reg.low_flag, s_reg.open_flag, 2'b00};

   always_comb begin
      case (s_reg.cmd)
         tsr_pkg::READ_TEMP_CMD:       rd_data = s_reg.temp;
         tsr_pkg::READ_STATUS_CMD:     rd_data = status_v;
         tsr_pkg::READ_CONFIG_CMD:     rd_data = s_reg.config_r;
         tsr_pkg::READ_RATE_CMD:       rd_data = s_reg.rate;
         tsr_pkg::READ_HIGH_LIMIT_CMD: rd_data = s_reg.high_lim;
         tsr_pkg::READ_LOW_LIMIT_CMD:  rd_data = s_reg.low_lim;
         default:                      rd_data = 8'hFF;
      endcase
   end

   always_comb begin
      if (ADC_RESULT > 10'sd127) begin
         sat = 8'h7F;
      end else if (ADC_RESULT < -10'sd128) begin
         sat = 8'h80;
      end else begin
         sat = ADC_RESULT[7:0];
      end
   end

   // reserved rate codes run at the fastest rate
   always_comb begin
      if (s_reg.rate > tsr_pkg::RATE_MAX_CODE) begin
         interval = SLOWEST_CYCLES >> 7;
      end else begin
         interval = SLOWEST_CYCLES >> s_reg.rate[2:0];
      end
   end

   assign scl_rise  = s_reg.scl_sy[1] & ~s_reg.scl_q;
   assign scl_fall  = ~s_reg.scl_sy[1] & s_reg.scl_q;
   assign start_c   = s_reg.scl_sy[1] & s_reg.scl_q & s_reg.sda_q & ~s_reg.sda_sy[1];
   assign stop_c    = s_reg.scl_sy[1] & s_reg.scl_q & ~s_reg.sda_q & s_reg.sda_sy[1];
   assign auto_mode = ~s_reg.config_r[tsr_pkg::CFG_STANDBY_BIT];
   assign conv_done = s_reg.busy && (s_reg.conv_cnt == 32'(CONV_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_next = s_reg;
      start_conv = 1'b0;
      s_next.scl_sy = {s_reg.scl_sy[0], SCL};
      s_next.sda_sy = {s_reg.sda_sy[0], SDA_IN};
      s_next.scl_q  = s_reg.scl_sy[1];
      s_next.sda_q  = s_reg.sda_sy[1];
      s_next.status_rd = 1'b0;

      if (start_c) begin
         s_next.bst     = tsr_pkg::BS_ADDR;
         s_next.bitcnt  = 4'h0;
         s_next.sda_oe  = 1'b0;
      end else if (stop_c) begin
         s_next.bst     = tsr_pkg::BS_IDLE;
         s_next.sda_oe  = 1'b0;
         s_next.bytenum = 2'd0;
      end else begin
         case (s_reg.bst)
            tsr_pkg::BS_IDLE: begin
               s_next.sda_oe = 1'b0;
            end
            tsr_pkg::BS_ADDR, tsr_pkg::BS_RXB: begin
               if (scl_rise) begin
                  s_next.shreg  = {s_reg.shreg[6:0], s_reg.sda_sy[1]};
                  s_next.bitcnt = s_reg.bitcnt + 4'h1;
               end
               if (scl_fall && s_reg.bitcnt == 4'h8) begin
                  s_next.bitcnt = 4'h0;
                  if (s_reg.bst == tsr_pkg::BS_ADDR) begin
                     s_next.is_read = s_reg.shreg[0];
                     s_next.is_ara  = s_reg.shreg[7:1] == tsr_pkg::ARA_ADDR;
                     if ((s_reg.shreg[7:1] == my_addr) ||
                         (s_reg.shreg[7:1] == tsr_pkg::ARA_ADDR && s_reg.shreg[0] && s_reg.alert)) begin
                        s_next.bst    = tsr_pkg::BS_AACK;
                        s_next.sda_oe = 1'b1;
                        if (!s_reg.shreg[0]) begin
                           s_next.bytenum = 2'd0;
                        end
                     end else begin
                        s_next.bst = tsr_pkg::BS_WAITP;
                     end
                  end else begin
                     s_next.bst    = tsr_pkg::BS_RACK;
                     s_next.sda_oe = 1'b1;
                     if (s_reg.bytenum == 2'd0) begin
                        s_next.cmd      = s_reg.shreg;
                        s_next.rd_valid = 1'b0;
                        if (s_reg.shreg == tsr_pkg::SINGLE_CONVERSION_CMD) begin
                           start_conv = ~s_reg.busy;
                        end
                     end else if (s_reg.bytenum == 2'd1) begin
                        case (s_reg.cmd)
                           tsr_pkg::WRITE_CONFIG_CMD:     s_next.config_r = s_reg.shreg & 8'h40;
                           tsr_pkg::WRITE_RATE_CMD:       s_next.rate = s_reg.shreg;
                           tsr_pkg::WRITE_HIGH_LIMIT_CMD: s_next.high_lim = s_reg.shreg;
                           tsr_pkg::WRITE_LOW_LIMIT_CMD:  s_next.low_lim = s_reg.shreg;
                           default: ;
                        endcase
                     end
                     s_next.bytenum = (s_reg.bytenum == 2'd3) ? 2'd3 : s_reg.bytenum + 2'd1;
                  end
               end
            end
            tsr_pkg::BS_AACK, tsr_pkg::BS_RACK: begin
               if (scl_fall) begin
                  if (s_reg.bst == tsr_pkg::BS_AACK && s_reg.is_read) begin
                     s_next.bst    = tsr_pkg::BS_TXB;
                     s_next.shreg  = s_reg.is_ara ? {my_addr, 1'b1} : rd_data;
                     s_next.sda_oe = s_reg.is_ara ? ~my_addr[6] : ~rd_data[7];
                     s_next.bitcnt = 4'h1;
                     s_next.status_rd = ~s_reg.is_ara && s_reg.cmd == tsr_pkg::READ_STATUS_CMD;
                  end else begin
                     s_next.bst    = tsr_pkg::BS_RXB;
                     s_next.sda_oe = 1'b0;
                     s_next.bitcnt = 4'h0;
                  end
               end
            end
            tsr_pkg::BS_TXB: begin
               if (scl_fall) begin
                  if (s_reg.bitcnt == 4'h8) begin
                     s_next.bst    = tsr_pkg::BS_TACK;
                     s_next.sda_oe = 1'b0;
                  end else begin
                     s_next.sda_oe = ~s_reg.shreg[3'd7 - 3'(s_reg.bitcnt)];
                     s_next.bitcnt = s_reg.bitcnt + 4'h1;
                  end
               end
            end
            tsr_pkg::BS_TACK: begin
               // host nack ends the byte; only one byte is served
               if (scl_rise) begin
                  s_next.bst = tsr_pkg::BS_WAITP;
               end
            end
            tsr_pkg::BS_WAITP: begin
               s_next.sda_oe = 1'b0;
            end
            default: begin
               s_next.bst = tsr_pkg::BS_IDLE;
            end
         endcase
      end

      // conversion engine
      if (s_reg.config_r[tsr_pkg::CFG_STANDBY_BIT] && !s_reg.single) begin
         s_next.busy = 1'b0;
      end
      if (s_reg.busy) begin
         s_next.conv_cnt = s_reg.conv_cnt + 32'd1;
      end
      if (conv_done && !(s_reg.config_r[tsr_pkg::CFG_STANDBY_BIT] && !s_reg.single)) begin
         s_next.temp      = sat;
         s_next.open_flag = ADC_OPEN;
         s_next.busy      = 1'b0;
         s_next.single    = 1'b0;
      end
      if (auto_mode && !s_reg.busy) begin
         if (s_reg.rate_cnt >= interval - 36'd1) begin
            s_next.rate_cnt = 36'd0;
            s_next.busy     = 1'b1;
            s_next.conv_cnt = 32'd0;
         end else begin
            s_next.rate_cnt = s_reg.rate_cnt + 36'd1;
         end
      end
      if (start_conv) begin
         s_next.busy     = 1'b1;
         s_next.single   = 1'b1;
         s_next.conv_cnt = 32'd0;
         s_next.rate_cnt = 36'd0;
      end

      // sticky alarms; set wins over the read clear
      if (s_reg.status_rd) begin
         s_next.high_flag = hi_cond;
         s_next.low_flag  = lo_cond;
      end
      if (hi_cond) begin
         s_next.high_flag = 1'b1;
      end
      if (lo_cond) begin
         s_next.low_flag = 1'b1;
      end
      // alert held while a limit is crossed, then until answered by the alert response read
      if (hi_cond || lo_cond) begin
         s_next.alert = 1'b1;
      end else if (s_reg.bst == tsr_pkg::BS_TACK && s_reg.is_ara) begin
         s_next.alert = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_reg          <= '0;
         s_reg.scl_sy   <= 2'b11;
         s_reg.sda_sy   <= 2'b11;
         s_reg.scl_q    <= 1'b1;
         s_reg.sda_q    <= 1'b1;
         s_reg.bst      <= tsr_pkg::BS_IDLE;
         s_reg.cmd      <= tsr_pkg::CMD_RESERVED;
         s_reg.config_r <= tsr_pkg::CONFIG_RESET;
         s_reg.rate     <= tsr_pkg::RATE_RESET;
         s_reg.high_lim <= tsr_pkg::HIGH_LIMIT_RESET;
         s_reg.low_lim  <= tsr_pkg::LOW_LIMIT_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         SDA_OE      <= 1'b0;
         ALERT_N_OE  <= 1'b0;
         CONV_ACTIVE <= 1'b0;
      end else begin
         SDA_OE      <= s_next.sda_oe;
         ALERT_N_OE  <= s_next.alert;
         CONV_ACTIVE <= s_next.busy;
      end
   end

   always_ff @(posedge CLK) begin
      SDA_OUT     <= 1'b0;
      ALERT_N_OUT <= 1'b0;
   end
endmodule // tsr_top

//--- tb/tsr_checker.sv
// assertions on the pins of the sensor register block
`timescale 1ns/1ps
module tsr_checker #(
   parameter logic [35:0] SLOWEST_CYCLES = 36'd1600,
   parameter int          CONV_CYCLES    = 20
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCL,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic ALERT_N_OUT,
   input wire logic ALERT_N_OE,
   input wire logic CONV_ACTIVE
);
   default clocking dcb @(posedge CLK); endclocking
   default disable iff (RST);
   logic [15:0] busy_cnt_reg;
   logic [3:0]  since_reg;
   logic [3:0]  scl_hi_reg;
   logic        conv_q_reg;
   always_ff @(posedge CLK) begin
      if (RST) begin
         busy_cnt_reg <= 16'h0;
         since_reg    <= 4'hF;
         scl_hi_reg   <= 4'h0;
         conv_q_reg   <= 1'b0;
      end else begin
         busy_cnt_reg <= CONV_ACTIVE ? busy_cnt_reg + 16'h1 : 16'h0;
         since_reg    <= (conv_q_reg && !CONV_ACTIVE) ? 4'h0 : (since_reg == 4'hF ? 4'hF : since_reg + 4'h1);
         scl_hi_reg   <= !SCL ? 4'h0 : (scl_hi_reg == 4'hF ? 4'hF : scl_hi_reg + 4'h1);
         conv_q_reg   <= CONV_ACTIVE;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_sda_low;
      SDA_OUT == 1'b0;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("sda data level not low");
   property p_alert_low;
      ALERT_N_OUT == 1'b0;
   endproperty
   a_alert_low: assert property (p_alert_low) else $error("alert data level not low");
   property p_busy_len;
      $fell(CONV_ACTIVE) |-> busy_cnt_reg >= CONV_CYCLES - 1 && busy_cnt_reg <= CONV_CYCLES + 1;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");
   property p_sda_hold;
      SCL && $past(SCL) && $past(SCL, 2) |-> $stable(SDA_OE);
   endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("sda moved while clock high");
   property p_alert_cause;
      $rose(ALERT_N_OE) |-> !CONV_ACTIVE && (since_reg <= 4'h4 || $fell(CONV_ACTIVE));
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert without conversion end");
   property p_idle_free;
      scl_hi_reg >= 4'hA |-> !SDA_OE;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("sda held on idle bus");
   property p_busy_min;
      $rose(CONV_ACTIVE) |=> CONV_ACTIVE [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("conversion ended early");
   property p_busy_gap;
      $fell(CONV_ACTIVE) |=> !CONV_ACTIVE [*2];
   endproperty
   a_busy_gap: assert property (p_busy_gap) else $error("conversion restarted at once");
endmodule // tsr_checker
bind tsr_top tsr_checker #(.SLOWEST_CYCLES(SLOWEST_CYCLES), .CONV_CYCLES(CONV_CYCLES)) i_chk (
   .CLK(CLK), .RST(RST), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .ALERT_N_OUT(ALERT_N_OUT), .ALERT_N_OE(ALERT_N_OE), .CONV_ACTIVE(CONV_ACTIVE));

//--- tb/tsr_host_model.sv
// smbus host controller model for the two-wire pins
`timescale 1ns/1ps
module tsr_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_host
);
   initial begin
      scl = 1'b1;
      sda_host = 1'b1;
   end
   task automatic q(input int c);
      repeat (c) @(posedge clk);
   endtask
   // one bit: 4 clocks low, 4 high, data moved mid low phase
   task automatic bit_x(input logic b, output logic s);
      sda_host <= b;
      q(2);
      scl <= 1'b1;
      q(3);
      s = sda_line;
      q(1);
      scl <= 1'b0;
      q(2);
   endtask
   task automatic start_c;
      sda_host <= 1'b1;
      q(2);
      scl <= 1'b1;
      q(4);
      sda_host <= 1'b0;
      q(4);
      scl <= 1'b0;
      q(2);
   endtask
   task automatic stop_c;
      sda_host <= 1'b0;
      q(2);
      scl <= 1'b1;
      q(4);
      sda_host <= 1'b1;
      q(4);
   endtask
   task automatic byte_out(input logic [7:0] b, inout int nk);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, s);
      nk += int'(s);
   endtask
   task automatic byte_in(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(1'b1, s);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic [6:0] a, input logic wc, input logic [7:0] c, input logic wd,
                       input logic [7:0] d, input logic r, output logic [7:0] rd, output int nk);
      nk = 0;
      rd = 8'hFF;
      start_c();
      if (wc) begin
         byte_out({a, 1'b0}, nk);
         byte_out(c, nk);
         if (wd) byte_out(d, nk);
         if (r) start_c();
      end
      if (r) begin
         byte_out({a, 1'b1}, nk);
         byte_in(rd);
      end
      stop_c();
   endtask
endmodule // tsr_host_model

//--- tb/tb_top.sv
// self-checking bench for the sensor register block
`timescale 1ns/1ps
module tb_top;
   localparam logic [6:0] DEV = 7'h18;
   logic              clk;
   logic              rst;
   logic              scl;
   logic              sda_host;
   logic              sda_oe;
   logic              alert_oe;
   logic              conv_active;
   logic signed [9:0] adc_result;
   logic              adc_open;
   logic [7:0]        rd;
   int                nk;
   int                n;
   int                fail_count;
   int                tests_run;
   logic [7:0]        rc [4] = '{8'h03, 8'h04, 8'h07, 8'h08};
   logic [7:0]        wc [4] = '{8'h09, 8'h0A, 8'h0D, 8'h0E};
   // low limit below the idle reading, so no alarm is raised before the first single conversion
   logic [7:0]        wd [4] = '{8'hFF, 8'h05, 8'h20, 8'hF0};
   logic [7:0]        we [4] = '{8'h40, 8'h05, 8'h20, 8'hF0};
   logic [7:0]        rv [4] = '{8'h00, 8'h02, 8'h7F, 8'hC9};
   wire logic         sda_line = sda_host & ~sda_oe;
   always #5 clk = ~clk;
   tsr_top #(.SLOWEST_CYCLES(36'd16000), .CONV_CYCLES(20)) i_dut (
      .CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(), .SDA_OE(sda_oe),
      .ALERT_N_OUT(), .ALERT_N_OE(alert_oe), .SA1(1'b0), .SA2_MODE(2'b00),
      .ADC_RESULT(adc_result), .ADC_OPEN(adc_open), .CONV_ACTIVE(conv_active));
   tsr_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_host(sda_host));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk1(input string w, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %b seen %b", w, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_lvl(input logic v, input int lim);
      n = 0;
      while (conv_active !== v) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            chk1("conversion wait", v, conv_active);
            final_report();
         end
      end
   endtask
   task automatic idle_check(input int cyc);
      logic seen;
      seen = 1'b0;
      repeat (cyc) begin
         @(posedge clk);
         if (conv_active !== 1'b0) seen = 1'b1;
      end
      chk1("no conversion", 1'b0, seen);
   endtask
   task automatic xf(input logic [6:0] a, input logic [2:0] k, input logic [7:0] c);
      i_host.xfer(a, k[2], c, k[1], 8'h00, k[0], rd, nk);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      i_host.xfer(DEV, 1'b1, c, 1'b1, d, 1'b0, rd, nk);
      chk8("write acks", 8'h00, nk[7:0]);
   endtask
   task automatic rdb(input logic [7:0] c, input logic [7:0] e);
      xf(DEV, 3'b101, c);
      chk8("read acks", 8'h00, nk[7:0]);
      chk8("read data", e, rd);
   endtask
   task automatic oneshot;
      xf(DEV, 3'b100, tsr_pkg::SINGLE_CONVERSION_CMD);
      chk8("send acks", 8'h00, nk[7:0]);
      wait_lvl(1'b0, 100);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      adc_result = 10'sd0;
      adc_open = 1'b0;
      fail_count = 0;
      tests_run = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      xf(DEV, 3'b001, 8'h00);
      chk8("pointer after reset", 8'hFF, rd);
      foreach (rc[i]) rdb(rc[i], rv[i]);
      xf(DEV, 3'b001, 8'h00);
      chk8("receive byte", 8'hC9, rd);
      wr(8'h05, 8'h00);
      rdb(8'h05, 8'hFF);
      rdb(tsr_pkg::READ_HIGH_LIMIT_CMD, 8'h7F);
      foreach (wc[i]) begin
         wr(wc[i], wd[i]);
         rdb(rc[i], we[i]);
      end
      idle_check(3000);
      adc_result <= 10'sd300;
      oneshot();
      rdb(tsr_pkg::READ_TEMP_CMD, 8'h7F);
      rdb(tsr_pkg::READ_STATUS_CMD, 8'h10);
      chk1("alert", 1'b1, alert_oe);
      xf(7'h0C, 3'b001, 8'h00);
      chk8("alert response", {DEV, 1'b1}, rd);
      rdb(tsr_pkg::READ_STATUS_CMD, 8'h10);
      idle_check(2000);
      adc_result <= -10'sd300;
      adc_open <= 1'b1;
      oneshot();
      rdb(tsr_pkg::READ_TEMP_CMD, 8'h80);
      rdb(tsr_pkg::READ_STATUS_CMD, 8'h1C);
      rdb(tsr_pkg::READ_STATUS_CMD, 8'h0C);
      xf(7'h19, 3'b101, tsr_pkg::READ_TEMP_CMD);
      chk8("foreign address acks", 8'h03, nk[7:0]);
      adc_result <= 10'sd0;
      adc_open <= 1'b0;
      wr(tsr_pkg::WRITE_CONFIG_CMD, 8'h00);
      for (int c = 5; c < 8; c++) begin
         wr(tsr_pkg::WRITE_RATE_CMD, 8'(c));
         wait_lvl(1'b1, 20000);
         wait_lvl(1'b0, 100);
         wait_lvl(1'b1, 20000);
         chk1("rate gap", 1'b1, n >= (16000 >> c) - 25 && n <= (16000 >> c) + 3);
      end
      wr(tsr_pkg::WRITE_RATE_CMD, 8'h03);
      repeat (2) begin
         wait_lvl(1'b1, 20000);
         wait_lvl(1'b0, 100);
      end
      repeat (800) @(posedge clk);
      oneshot();
      wait_lvl(1'b1, 3000);
      chk1("timer restart", 1'b1, n >= 1900 && n <= 2010);
      wait_lvl(1'b0, 100);
      wr(tsr_pkg::WRITE_CONFIG_CMD, 8'h40);
      idle_check(3000);
      final_report();
   end
endmodule // tb_top
